// ===== verilog/iis_pkg.sv
// shared constants, field layouts and carrier types for the interrupt priority status block
`default_nettype none
package iis_pkg;
    // register byte offsets on the wishbone bus
    localparam logic [7:0] ADDR_STATUS_WORD = 8'h00;
    localparam logic [7:0] ADDR_CORE_CTRL = 8'h04;
    localparam logic [7:0] ADDR_PENDING = 8'h08;
    localparam logic [7:0] ADDR_USER_PRIO = 8'h0C;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h10;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h14;
    // field positions
    localparam int PRIO_LSB = 5;
    localparam int PRIO_MSB = 7;
    localparam int TOP_BIT_POS = 3;
    localparam int LEVEL_LSB = 8;
    localparam int LEVEL_MSB = 11;
    localparam int VEC_MSB = 7;
    // source counts and vector map
    localparam int NUM_TRAPS = 6;
    localparam int NUM_USER = 8;
    localparam logic [7:0] VEC_USER_BASE = 8'h08;
    localparam logic [3:0] TRAP_TOP_LEVEL = 4'hF;
    // event bits of the interrupt status register
    localparam int EVT_W = 2;
    localparam int EVT_NEW_PEND = 0;
    localparam int EVT_TRAP = 1;
    // reset values
    localparam logic [2:0] PRIO_RESET = 3'h0;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef logic [EVT_W-1:0] iis_evt_t;

    // pending interrupt as latched into the status register
    typedef struct packed {
        logic [3:0] level;
        logic [7:0] vector;
    } iis_pend_s;

    // candidate out of the resolver
    typedef struct packed {
        logic valid;
        iis_pend_s pend;
    } iis_cand_s;

    // trap priorities are fixed and all above any user level
    function automatic logic [3:0] trapLevel(input int idx);
        trapLevel = TRAP_TOP_LEVEL - 4'(idx);
    endfunction
endpackage
`default_nettype wire

// ===== verilog/iis_resolver.sv
// picks the highest-priority pending source; ties go to the lower vector
`default_nettype none
module iis_resolver (
    input wire logic [iis_pkg::NUM_TRAPS-1:0] trapReq,
    input wire logic [iis_pkg::NUM_USER-1:0] userReq,
    input wire logic [3*iis_pkg::NUM_USER-1:0] userPrio,
    output iis_pkg::iis_cand_s cand
);
    import iis_pkg::*;

    // scan in natural order, only a strictly higher level displaces the winner
    always_comb begin
        cand = '0;
        for (int i = 0; i < NUM_TRAPS; i++) begin
            if (trapReq[i] && (!cand.valid || trapLevel(i) > cand.pend.level)) begin
                cand.valid = 1'b1;
                cand.pend.level = trapLevel(i);
                cand.pend.vector = 8'(i);
            end
        end
        for (int j = 0; j < NUM_USER; j++) begin
            // level 0 sources are disabled, as a zero level never beats the cpu
            if (userReq[j] && userPrio[3*j +: 3] != 3'h0 &&
                (!cand.valid || {1'b0, userPrio[3*j +: 3]} > cand.pend.level)) begin
                cand.valid = 1'b1;
                cand.pend.level = {1'b0, userPrio[3*j +: 3]};
                cand.pend.vector = VEC_USER_BASE + 8'(j);
            end
        end
    end
endmodule // iis_resolver

// ===== verilog/iis_event_flags.sv
// sticky event status, write-one-to-clear, with mask and level interrupt
`default_nettype none
module iis_event_flags (
    input wire logic clk,
    input wire logic rst,
    input wire iis_pkg::iis_evt_t evtSet,
    input wire logic statusWr,
    input wire logic maskWr,
    input wire iis_pkg::iis_evt_t wrData,
    output iis_pkg::iis_evt_t status,
    output iis_pkg::iis_evt_t mask,
    output logic irq
);
    import iis_pkg::*;

    iis_evt_t status_q, status_d, mask_q, mask_d;
    logic irq_q, irq_d;

    // a set arriving with its own clear survives, so no event is lost
    always_comb begin
        status_d = status_q;
        if (statusWr) begin
            status_d = status_q & ~wrData;
        end
        status_d = status_d | evtSet;
        mask_d = maskWr ? wrData : mask_q;
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign status = status_q;
    assign mask = mask_q;
    assign irq = irq_q;

    a_set_wins_clear: assert property (@(posedge clk) disable iff (rst)
        (evtSet[EVT_NEW_PEND] && statusWr) |=> status_q[EVT_NEW_PEND])
        else $error("event set lost against clear");
endmodule // iis_event_flags

// ===== verilog/iis_top.sv
// current cpu priority level and pending interrupt status, wishbone register slave
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none
module iis_top (
    input wire logic clk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt and trap sources, same clock
    input wire logic [iis_pkg::NUM_TRAPS-1:0] trapReq,
    input wire logic [iis_pkg::NUM_USER-1:0] userReq,
    // processor core side
    input wire logic coreTake,
    input wire logic coreRestore,
    input wire logic [3:0] restoreLevel,
    output logic pendValid,
    output iis_pkg::iis_pend_s pendOut,
    output logic [3:0] curLevel,
    output logic irqOut
);
    import iis_pkg::*;

    logic [2:0] prio_q, prio_d;
    logic topBit_q, topBit_d;
    iis_pend_s pend_q, pend_d;
    logic pendValid_q, pendValid_d;
    logic [3*NUM_USER-1:0] userPrio_q, userPrio_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    iis_cand_s cand;
    logic candHit;
    iis_evt_t evtSet, evtStatus, evtMask;
    logic reqNew, wrStrobe, evtStatusWr, evtMaskWr, takeNow;
    logic [7:0] wordAdr;

    iis_resolver u_resolver (
        .trapReq(trapReq),
        .userReq(userReq),
        .userPrio(userPrio_q),
        .cand(cand)
    );

    // bus decode; the slave answers one cycle after a request appears
    always_comb begin
        wordAdr = {wb_adr_i[7:2], 2'b00};
        reqNew = wb_cyc_i && wb_stb_i && !ack_q;
        wrStrobe = reqNew && wb_we_i;
        evtStatusWr = wrStrobe && wb_sel_i[0] && wordAdr == ADDR_EVT_STATUS;
        evtMaskWr = wrStrobe && wb_sel_i[0] && wordAdr == ADDR_EVT_MASK;
        takeNow = coreTake && pendValid_q;
    end

    // pending capture: only a source above the current level is reported
    always_comb begin
        candHit = cand.valid && cand.pend.level > {topBit_q, prio_q};
        pend_d = pend_q;
        pendValid_d = 1'b0;
        if (candHit) begin
            pend_d = cand.pend;
            pendValid_d = 1'b1;
        end
        // an event is a new pending source, not one that merely stays pending
        evtSet = '0;
        evtSet[EVT_NEW_PEND] = candHit && (!pendValid_q || cand.pend != pend_q);
        evtSet[EVT_TRAP] = evtSet[EVT_NEW_PEND] && cand.pend.vector < 8'(NUM_TRAPS);
    end

    // current level; the core's take or restore beats a software write
    always_comb begin
        prio_d = prio_q;
        topBit_d = topBit_q;
        if (takeNow) begin
            {topBit_d, prio_d} = pend_q.level;
        end else if (coreRestore) begin
            {topBit_d, prio_d} = restoreLevel;
        end else if (wrStrobe && wb_sel_i[0] && wordAdr == ADDR_STATUS_WORD) begin
            // top bit is never touched here, so traps stay unmaskable
            prio_d = wb_dat_i[PRIO_MSB:PRIO_LSB];
        end
    end

    // user priority register, byte lanes honoured
    always_comb begin
        userPrio_d = userPrio_q;
        if (wrStrobe && wordAdr == ADDR_USER_PRIO) begin
            for (int b = 0; b < 3; b++) begin
                if (wb_sel_i[b]) begin
                    userPrio_d[8*b +: 8] = wb_dat_i[8*b +: 8];
                end
            end
        end
    end

    // read mux; unmapped addresses answer with zero and drop writes
    always_comb begin
        ack_d = reqNew;
        dat_d = DATA_ZERO;
        if (reqNew && !wb_we_i) begin
            case (wordAdr)
                ADDR_STATUS_WORD: dat_d[PRIO_MSB:PRIO_LSB] = prio_q;
                ADDR_CORE_CTRL: dat_d[TOP_BIT_POS] = topBit_q;
                ADDR_PENDING: begin
                    // bits 15..12 stay zero
                    dat_d[LEVEL_MSB:LEVEL_LSB] = pend_q.level;
                    dat_d[VEC_MSB:0] = pend_q.vector;
                end
                ADDR_USER_PRIO: dat_d[3*NUM_USER-1:0] = userPrio_q;
                ADDR_EVT_STATUS: dat_d[EVT_W-1:0] = evtStatus;
                ADDR_EVT_MASK: dat_d[EVT_W-1:0] = evtMask;
                default: dat_d = DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prio_q <= PRIO_RESET;
            topBit_q <= 1'b0;
            pend_q <= '0;
            pendValid_q <= 1'b0;
            userPrio_q <= '0;
            ack_q <= 1'b0;
            dat_q <= DATA_ZERO;
        end else begin
            prio_q <= prio_d;
            topBit_q <= topBit_d;
            pend_q <= pend_d;
            pendValid_q <= pendValid_d;
            userPrio_q <= userPrio_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    iis_event_flags u_flags (
        .clk(clk),
        .rst(rst),
        .evtSet(evtSet),
        .statusWr(evtStatusWr),
        .maskWr(evtMaskWr),
        .wrData(wb_dat_i[EVT_W-1:0]),
        .status(evtStatus),
        .mask(evtMask),
        .irq(irqOut)
    );

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign pendValid = pendValid_q;
    assign pendOut = pend_q;
    assign curLevel = {topBit_q, prio_q};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_swWrite;
        wrStrobe && wb_sel_i[0] && wordAdr == ADDR_STATUS_WORD && !coreTake && !coreRestore;
    endsequence
    sequence s_readOf(logic [7:0] a);
        reqNew && !wb_we_i && wordAdr == a;
    endsequence

    a_sw_level_write: assert property (s_swWrite |=> prio_q == $past(wb_dat_i[7:5]))
        else $error("software level write not applied");
    a_top_bit_ro: assert property (s_swWrite |=> $stable(topBit_q))
        else $error("software changed the top priority bit");
    a_status_bits_read: assert property (s_readOf(ADDR_STATUS_WORD)
        |=> wb_ack_o && wb_dat_o[7:5] == $past(prio_q))
        else $error("status word bits 7..5 wrong");
    a_take_full_level: assert property (coreTake && pendValid_q
        |=> curLevel == $past(pend_q.level))
        else $error("take did not load the four-bit level");
    a_pend_read_layout: assert property (s_readOf(ADDR_PENDING)
        |=> wb_dat_o[11:8] == $past(pend_q.level) && wb_dat_o[15:12] == 4'h0)
        else $error("pending level field wrong");
    a_pend_latch_pair: assert property (candHit
        |=> pendValid_q && pend_q.vector == $past(cand.pend.vector)
            && pend_q.level == $past(cand.pend.level))
        else $error("vector and level not latched together");
    a_pend_above_cur: assert property (pendValid_q && !$past(coreTake) && !$past(coreRestore)
        |-> pend_q.level > $past(curLevel))
        else $error("pending level not above current level");
    a_first_ext_vec: assert property (trapReq == '0 && userReq == 8'h01
        && userPrio_q[2:0] > curLevel[2:0] && !topBit_q |=> pend_q.vector == 8'h08)
        else $error("first external input not vector 8");
    a_trap_vectors: assert property (trapReq[0] && curLevel != 4'hF
        |=> pendValid_q && pend_q.vector == 8'h00 && pend_q.level == 4'hF)
        else $error("oscillator trap not vector 0");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule // iis_top
`default_nettype wire

// ===== testbench/iis_core_model.sv
// processor core model: takes the pending interrupt after a programmable lag
`default_nettype none
module iis_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic takeEn,
    input wire logic [3:0] lag,
    input wire logic pendValid,
    input wire iis_pkg::iis_pend_s pendOut,
    output logic coreTake,
    output logic [7:0] takenVec
);
    timeunit 1ns;
    timeprecision 1ns;
    import iis_pkg::*;
    logic [3:0] waitCnt_q;
    logic done_q;
    // one take per enable and only while something is pending, as a real core would
    always_ff @(posedge clk) begin
        if (rst || !takeEn) begin
            waitCnt_q <= 4'h0;
            done_q <= 1'b0;
            coreTake <= 1'b0;
        end else begin
            coreTake <= 1'b0;
            if (!done_q && pendValid) begin
                if (waitCnt_q >= lag) begin
                    coreTake <= 1'b1;
                    takenVec <= pendOut.vector;
                    done_q <= 1'b1;
                end else begin
                    waitCnt_q <= waitCnt_q + 4'h1;
                end
            end
        end
    end
endmodule // iis_core_model
`default_nettype wire

// ===== testbench/interrupt_priority_status_tb.sv
// self-checking bench for the interrupt priority status block
`default_nettype none
module interrupt_priority_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import iis_pkg::*;
    logic clk, rst, cyc, stb, we, ack, coreTake, coreRestore, takeEn, pendValid, irqOut;
    logic [7:0] adr, takenVec;
    logic [3:0] sel, restoreLevel, curLevel, lag;
    logic [31:0] datI, datO, rd;
    logic [NUM_TRAPS-1:0] trapReq;
    logic [NUM_USER-1:0] userReq;
    iis_pend_s pendOut;
    int errors, nTests;
    logic [3:0] laneMask;

    iis_top DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
        .trapReq(trapReq), .userReq(userReq), .coreTake(coreTake), .coreRestore(coreRestore),
        .restoreLevel(restoreLevel), .pendValid(pendValid), .pendOut(pendOut),
        .curLevel(curLevel), .irqOut(irqOut));
    iis_core_model coreModel (.clk(clk), .rst(rst), .takeEn(takeEn), .lag(lag),
        .pendValid(pendValid), .pendOut(pendOut), .coreTake(coreTake), .takenVec(takenVec));

    // 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] expV);
        nTests++;
        if (got !== expV) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, expV);
        end
    endtask

    // one classic wishbone cycle; read data lands in rd at the ack edge
    task automatic wbXfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= laneMask;
        datI <= d;
        // no answer time is assumed; the watchdog ends a bus that never answers
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] expV);
        wbXfer(a, 1'b0, 32'h0);
        check(rd, expV);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        tally_and_finish;
    end

    initial begin
        logic [31:0] expV;
        errors = 0;
        nTests = 0;
        rst = 1'b1;
        {cyc, stb, we, coreRestore, takeEn} = 5'h00;
        {adr, sel, datI, restoreLevel, lag} = 52'h0;
        trapReq = 6'h00;
        userReq = 8'h00;
        laneMask = 4'hF;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdChk(ADDR_PENDING, 32'h0000_0000);
        rdChk(ADDR_STATUS_WORD, 32'h0000_0000);
        // only bits 7:5 of the status word may stick
        wbXfer(ADDR_STATUS_WORD, 1'b1, 32'h0000_00FF);
        rdChk(ADDR_STATUS_WORD, 32'h0000_00E0);
        check(32'(curLevel), 32'h7);
        // software must not be able to lift the level into trap range
        wbXfer(ADDR_CORE_CTRL, 1'b1, 32'hFFFF_FFFF);
        rdChk(ADDR_CORE_CTRL, 32'h0000_0000);
        check(32'(curLevel), 32'h7);
        // with byte lane 0 off the level write must be dropped
        laneMask = 4'hE;
        wbXfer(ADDR_STATUS_WORD, 1'b1, 32'h0000_0000);
        laneMask = 4'hF;
        rdChk(ADDR_STATUS_WORD, 32'h0000_00E0);
        wbXfer(ADDR_STATUS_WORD, 1'b1, 32'h0000_0000);
        rdChk(8'h1C, 32'h0000_0000);
        // every trap alone: fixed vector, level 15 minus vector, top nibble zero
        for (int i = 0; i < NUM_TRAPS; i++) begin
            expV = {20'h0, 4'(15 - i), 8'(i)};
            @(posedge clk) trapReq <= 6'(1 << i);
            repeat (3) @(posedge clk);
            rdChk(ADDR_PENDING, expV);
            check({20'h0, pendOut}, expV);
            @(posedge clk) trapReq <= 6'h00;
        end
        // traps raised both sticky bits; mask still clear so the line stays low
        rdChk(ADDR_EVT_STATUS, 32'h0000_0003);
        check(32'(irqOut), 32'h0);
        // source 0 at priority 3, source 1 at priority 5
        wbXfer(ADDR_USER_PRIO, 1'b1, 32'h0000_002B);
        wbXfer(ADDR_EVT_STATUS, 1'b1, 32'h0000_0003);
        wbXfer(ADDR_EVT_MASK, 1'b1, 32'h0000_0001);
        @(posedge clk) userReq <= 8'h01;
        repeat (3) @(posedge clk);
        rdChk(ADDR_PENDING, 32'h0000_0308);
        rdChk(ADDR_EVT_STATUS, 32'h0000_0001);
        check(32'(irqOut), 32'h1);
        @(posedge clk) userReq <= 8'h03;
        repeat (3) @(posedge clk);
        rdChk(ADDR_PENDING, 32'h0000_0509);
        // a slow core takes it; the lower source is then refused
        @(posedge clk) begin
            lag <= 4'h3;
            takeEn <= 1'b1;
        end
        repeat (12) @(posedge clk);
        check(32'(takenVec), 32'h9);
        check(32'(curLevel), 32'h5);
        check(32'(pendValid), 32'h0);
        // return to level 0 brings source 1 back
        @(posedge clk) begin
            takeEn <= 1'b0;
            coreRestore <= 1'b1;
            restoreLevel <= 4'h0;
        end
        @(posedge clk) coreRestore <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'(pendValid), 32'h1);
        check({20'h0, pendOut}, 32'h0000_0509);
        // masking drops the line, then write-one clears the sticky bits
        wbXfer(ADDR_EVT_MASK, 1'b1, 32'h0000_0000);
        repeat (2) @(posedge clk);
        check(32'(irqOut), 32'h0);
        @(posedge clk) userReq <= 8'h00;
        wbXfer(ADDR_EVT_STATUS, 1'b1, 32'h0000_0003);
        rdChk(ADDR_EVT_STATUS, 32'h0000_0000);
        tally_and_finish;
    end
endmodule // interrupt_priority_status_tb
`default_nettype wire
